// file: inc/trc_pkg.sv
package trc_pkg;

  // ****************************************
  // Spaces and sizes
  // ****************************************
  localparam int PC_W = 10;
  localparam int NIRQ_DEF = 2;
  localparam int PORT_W = 5;
  localparam int SRAM_BYTES = 128;
  localparam int EE_BYTES = 128;
  localparam logic [7:0] IO_BASE = 8'h20;
  localparam logic [7:0] SRAM_BASE = 8'h60;
  localparam logic [7:0] SRAM_END = 8'hE0;
  localparam logic [7:0] SP_RST = 8'h00;

  // ****************************************
  // I/O space
  // ****************************************
  localparam logic [5:0] IO_STATUS = 6'h3F;
  localparam logic [5:0] IO_STACK = 6'h3D;
  localparam logic [5:0] IO_IRQ_MASK = 6'h3B;
  localparam logic [5:0] IO_SLEEP_CTL = 6'h35;
  localparam logic [5:0] IO_EE_ADDR = 6'h1E;
  localparam logic [5:0] IO_EE_DATA = 6'h1D;
  localparam logic [5:0] IO_EE_CTL = 6'h1C;
  localparam logic [5:0] IO_PORT_DATA = 6'h18;
  localparam logic [5:0] IO_PORT_DIR = 6'h17;
  localparam logic [5:0] IO_PORT_PIN = 6'h16;
  localparam int ST_I = 7;
  localparam int ST_N = 2;
  localparam int ST_Z = 1;
  localparam int ST_C = 0;
  localparam int SLP_EN = 5;
  localparam int SLP_PD = 4;
  localparam int EE_RD = 0;
  localparam int EE_WR = 1;

  // ****************************************
  // Bus registers
  // ****************************************
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_PADDR = 12'h008;
  localparam logic [11:0] A_PDATA = 12'h00C;
  localparam logic [11:0] A_DADDR = 12'h010;
  localparam logic [11:0] A_DDATA = 12'h014;
  localparam int CTRL_RUN = 0;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 25;
  localparam int OSC_NOM_HZ = 1000000;
  localparam int RST_MIN_NS = 50;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [7:0] {
    ST_HALT = 8'h01, ST_RUN = 8'h02, ST_CALL = 8'h04, ST_RET1 = 8'h08,
    ST_RET2 = 8'h10, ST_LONG = 8'h20, ST_IDLE = 8'h40, ST_PDOWN = 8'h80
  } trc_state_e_t;

  typedef struct packed {
    logic awvalid; logic [11:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [11:0] araddr;
    logic rready;
  } trc_axi_req_t;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } trc_axi_rsp_t;

  typedef struct packed {
    trc_state_e_t st; logic [PC_W-1:0] instruction_counter;
    logic [15:0] ir; logic [PC_W-1:0] ir_addr; logic ir_ok;
    logic [7:0] stack_top_pointer; logic [7:0] sreg; logic [7:0] irq_mask;
    logic [7:0] slp; logic [1:0] ret_hi; logic reti; logic lds_st;
    logic [4:0] lds_r; logic [6:0] eear; logic [7:0] eedr;
    logic [PORT_W-1:0] pdat; logic [PORT_W-1:0] pdir; logic [PORT_W-1:0] pull;
    logic [PORT_W-1:0] pin_s1; logic [PORT_W-1:0] pin_s2;
    logic rst_s1; logic rst_s2; logic [1:0] rst_cnt; logic core_rst;
    logic idle; logic osc_halt; logic run; logic [PC_W-1:0] paddr;
    logic [7:0] daddr; logic aw_ok; logic [11:0] aw_a; logic w_ok;
    logic [31:0] w_d; logic [3:0] w_s; trc_axi_rsp_t rsp;
  } trc_state_t;

endpackage : trc_pkg

// file: rtl/trc_core.sv
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module trc_core #(
  parameter int NIRQ = trc_pkg::NIRQ_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_reset_n,
  input wire logic [NIRQ-1:0] irq_req,
  input wire logic [trc_pkg::PORT_W-1:0] port_b_pins_in,
  output logic [trc_pkg::PORT_W-1:0] port_b_pins_out,
  output logic [trc_pkg::PORT_W-1:0] port_b_pins_oe,
  output logic [trc_pkg::PORT_W-1:0] port_b_pullup,
  output logic cpu_idle,
  output logic osc_halt,
  input wire trc_pkg::trc_axi_req_t axi_req,
  output trc_pkg::trc_axi_rsp_t axi_rsp
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] rf [32];
  logic [7:0] sram [trc_pkg::SRAM_BYTES];
  logic [7:0] eeprom [trc_pkg::EE_BYTES];
  logic [15:0] pmem [1 << trc_pkg::PC_W];
  trc_pkg::trc_state_t s;
  trc_pkg::trc_state_t next_s;
  logic dw_en;
  logic [7:0] dw_a;
  logic [7:0] dw_d;
  logic pm_we;
  logic [15:0] pm_d;
  logic ee_we;
  logic take;
  logic hold;
  logic [NIRQ-1:0] pend;
  logic [9:0] vec;
  logic [9:0] ret;
  logic [8:0] res;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] k8;
  logic [4:0] dh;
  logic [15:0] zw;
  logic [7:0] rd8;

  function automatic logic [7:0] io_rd(input logic [5:0] ia);
    case (ia)
      trc_pkg::IO_STATUS: io_rd = s.sreg;
      trc_pkg::IO_STACK: io_rd = s.stack_top_pointer;
      trc_pkg::IO_IRQ_MASK: io_rd = s.irq_mask;
      trc_pkg::IO_SLEEP_CTL: io_rd = s.slp;
      trc_pkg::IO_EE_ADDR: io_rd = {1'b0, s.eear};
      trc_pkg::IO_EE_DATA: io_rd = s.eedr;
      trc_pkg::IO_PORT_DATA: io_rd = 8'(s.pdat);
      trc_pkg::IO_PORT_DIR: io_rd = 8'(s.pdir);
      trc_pkg::IO_PORT_PIN: io_rd = 8'(s.pin_s2);
      default: io_rd = 8'h00;
    endcase
  endfunction : io_rd

  // Registers, then I/O, then SRAM, in one linear data space
  function automatic logic [7:0] d_rd(input logic [7:0] da);
    if (da < trc_pkg::IO_BASE)
      d_rd = rf[da[4:0]];
    else if (da < trc_pkg::SRAM_BASE)
      d_rd = io_rd(6'(da - trc_pkg::IO_BASE));
    else if (da < trc_pkg::SRAM_END)
      d_rd = sram[7'(da - trc_pkg::SRAM_BASE)];
    else
      d_rd = 8'h00;
  endfunction : d_rd

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_s = s;
    dw_en = 1'b0;
    dw_a = 8'h00;
    dw_d = 8'h00;
    pm_we = 1'b0;
    pm_d = 16'h0000;
    ee_we = 1'b0;
    take = 1'b0;
    hold = 1'b0;
    vec = 10'h000;
    ret = 10'h000;
    res = 9'h000;
    rd8 = 8'h00;
    pend = irq_req & s.irq_mask[NIRQ-1:0];
    next_s.pin_s1 = port_b_pins_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.rst_s1 = ext_reset_n;
    next_s.rst_s2 = s.rst_s1;
    // Held low for the least pulse width before the core is reset
    next_s.rst_cnt = s.rst_s2 ? 2'h0 : (s.rst_cnt == 2'h3 ? s.rst_cnt : s.rst_cnt + 2'h1);
    next_s.core_rst = !s.rst_s2 && (s.rst_cnt >= 2'(trc_pkg::RST_MIN_CYC - 1));
    for (int i = NIRQ - 1; i >= 0; i--)
    begin
      if (pend[i])
        vec = 10'(i + 1);
    end
    a = rf[s.ir[8:4]];
    b = rf[{s.ir[9], s.ir[3:0]}];
    k8 = {s.ir[11:8], s.ir[3:0]};
    dh = {1'b1, s.ir[7:4]};
    zw = {rf[31], rf[30]};
    // Prefetch: the word at the counter is fetched while ir executes
    next_s.ir = pmem[s.instruction_counter];
    next_s.ir_addr = s.instruction_counter;
    next_s.instruction_counter = s.instruction_counter + 10'h001;
    next_s.ir_ok = 1'b1;
    case (s.st)
      trc_pkg::ST_HALT:
      begin
        hold = 1'b1;
        if (s.run)
          next_s.st = trc_pkg::ST_RUN;
      end
      trc_pkg::ST_RUN:
      begin
        if (!s.run)
        begin
          hold = 1'b1;
          next_s.st = trc_pkg::ST_HALT;
        end
        else if (s.sreg[trc_pkg::ST_I] && |pend)
        begin
          take = 1'b1;
          ret = s.ir_ok ? s.ir_addr : s.instruction_counter;
          dw_en = 1'b1;
          dw_a = s.stack_top_pointer;
          dw_d = ret[7:0];
          next_s.ret_hi = ret[9:8];
          next_s.stack_top_pointer = s.stack_top_pointer - 8'h01;
          next_s.sreg[trc_pkg::ST_I] = 1'b0;
          next_s.instruction_counter = vec;
          next_s.ir_ok = 1'b0;
          next_s.st = trc_pkg::ST_CALL;
        end
        else if (s.ir_ok)
        begin
          casez (s.ir)
            16'b0000_11??_????_????, 16'b0001_11??_????_????:
            begin
              res = {1'b0, a} + {1'b0, b} + ((s.ir[12]) ? 9'(s.sreg[trc_pkg::ST_C]) : 9'h000);
              dw_en = 1'b1;
              dw_a = {3'h0, s.ir[8:4]};
              dw_d = res[7:0];
            end
            16'b0001_01??_????_????, 16'b0001_10??_????_????, 16'b0101_????_????_????:
            begin
              res = {1'b0, a} - {1'b0, b};
              if (s.ir[14])
                res = {1'b0, rf[dh]} - {1'b0, k8};
              dw_en = s.ir[11] || s.ir[14]; // compare only sets flags
              dw_a = s.ir[14] ? {3'h0, dh} : {3'h0, s.ir[8:4]};
              dw_d = res[7:0];
            end
            16'b0010_????_????_????:
            begin
              case (s.ir[11:10])
                2'h0: res = {1'b0, a & b};
                2'h1: res = {1'b0, a ^ b};
                2'h2: res = {1'b0, a | b};
                default: res = {s.sreg[trc_pkg::ST_C], b};
              endcase
              dw_en = 1'b1;
              dw_a = {3'h0, s.ir[8:4]};
              dw_d = res[7:0];
            end
            16'b011?_????_????_????, 16'b1110_????_????_????:
            begin
              res = {s.sreg[trc_pkg::ST_C], s.ir[15] ? k8 :
                (s.ir[12] ? rf[dh] & k8 : rf[dh] | k8)};
              dw_en = 1'b1;
              dw_a = {3'h0, dh};
              dw_d = res[7:0];
            end
            16'b1100_????_????_????:
            begin
              next_s.instruction_counter = s.ir_addr + 10'h001 + s.ir[9:0];
              next_s.ir_ok = 1'b0;
            end
            16'b1101_????_????_????:
            begin
              ret = s.ir_addr + 10'h001;
              dw_en = 1'b1;
              dw_a = s.stack_top_pointer;
              dw_d = ret[7:0];
              next_s.ret_hi = ret[9:8];
              next_s.stack_top_pointer = s.stack_top_pointer - 8'h01;
              next_s.instruction_counter = s.ir_addr + 10'h001 + s.ir[9:0];
              next_s.ir_ok = 1'b0;
              next_s.st = trc_pkg::ST_CALL;
            end
            16'b1111_0???_????_?001:
            begin
              if (s.sreg[trc_pkg::ST_Z] ^ s.ir[10])
              begin
                next_s.instruction_counter = s.ir_addr + 10'h001 + {{3{s.ir[9]}}, s.ir[9:3]};
                next_s.ir_ok = 1'b0;
              end
            end
            16'b1011_????_????_????:
            begin
              dw_en = 1'b1;
              dw_a = s.ir[11] ? 8'(trc_pkg::IO_BASE + {s.ir[10:9], s.ir[3:0]}) :
                {3'h0, s.ir[8:4]};
              dw_d = s.ir[11] ? a : io_rd({s.ir[10:9], s.ir[3:0]});
            end
            16'b100?00??????1100, 16'b1000_00??_????_?000:
            begin
              // X, Y or Z selects the data address
              rd8 = s.ir[2] ? rf[26] : (s.ir[3] ? rf[28] : rf[30]);
              dw_en = 1'b1;
              dw_a = s.ir[9] ? rd8 : {3'h0, s.ir[8:4]};
              dw_d = s.ir[9] ? a : d_rd(rd8);
            end
            16'b1001_00??????0000:
            begin
              next_s.lds_st = s.ir[9];
              next_s.lds_r = s.ir[8:4];
              next_s.st = trc_pkg::ST_LONG;
            end
            16'b1001_0101_000?1000:
            begin
              next_s.reti = s.ir[4];
              next_s.st = trc_pkg::ST_RET1;
            end
            16'b1001_0101_1000_1000:
            begin
              if (s.slp[trc_pkg::SLP_EN])
              begin
                // Fetch goes on, so a wake resumes past the sleep word
                next_s.st = s.slp[trc_pkg::SLP_PD] ? trc_pkg::ST_PDOWN : trc_pkg::ST_IDLE;
              end
            end
            16'b1001_0101_1100_1000:
            begin
              pm_d = pmem[zw[10:1]];
              dw_en = 1'b1;
              dw_a = 8'h00;
              dw_d = zw[0] ? pm_d[15:8] : pm_d[7:0];
              pm_d = 16'h0000;
            end
            16'b1001_0100_?111_1000:
              next_s.sreg[trc_pkg::ST_I] = !s.ir[7];
            default: ;
          endcase
          if (s.ir[15:14] != 2'h2 && s.ir[15:12] != 4'hC && s.ir[15:12] != 4'hD
              && s.ir[15:12] != 4'hE && s.ir[15:13] != 3'h7 && !(s.ir[11:10] == 2'h3
              && s.ir[15:12] == 4'h2))
          begin
            next_s.sreg[trc_pkg::ST_Z] = (res[7:0] == 8'h00);
            next_s.sreg[trc_pkg::ST_N] = res[7];
            next_s.sreg[trc_pkg::ST_C] = res[8];
          end
        end
      end
      trc_pkg::ST_CALL:
      begin
        dw_en = 1'b1;
        dw_a = s.stack_top_pointer;
        dw_d = {6'h00, s.ret_hi};
        next_s.stack_top_pointer = s.stack_top_pointer - 8'h01;
        next_s.st = trc_pkg::ST_RUN;
      end
      trc_pkg::ST_RET1:
      begin
        rd8 = d_rd(s.stack_top_pointer + 8'h01);
        next_s.ret_hi = rd8[1:0];
        next_s.stack_top_pointer = s.stack_top_pointer + 8'h01;
        next_s.st = trc_pkg::ST_RET2;
      end
      trc_pkg::ST_RET2:
      begin
        next_s.instruction_counter = {s.ret_hi, d_rd(s.stack_top_pointer + 8'h01)};
        next_s.stack_top_pointer = s.stack_top_pointer + 8'h01;
        next_s.ir_ok = 1'b0;
        if (s.reti)
          next_s.sreg[trc_pkg::ST_I] = 1'b1;
        next_s.st = trc_pkg::ST_RUN;
      end
      trc_pkg::ST_LONG:
      begin
        dw_en = 1'b1;
        dw_a = s.lds_st ? s.ir[7:0] : {3'h0, s.lds_r};
        dw_d = s.lds_st ? rf[s.lds_r] : d_rd(s.ir[7:0]);
        next_s.st = trc_pkg::ST_RUN;
      end
      default:
      begin
        // Idle and power-down wait here; any enabled source wakes
        hold = 1'b1;
        if (|pend)
          next_s.st = trc_pkg::ST_RUN;
      end
    endcase
    if (hold)
    begin
      next_s.ir = s.ir;
      next_s.ir_addr = s.ir_addr;
      next_s.instruction_counter = s.instruction_counter;
      next_s.ir_ok = s.ir_ok;
    end
    if (dw_en && dw_a >= trc_pkg::IO_BASE && dw_a < trc_pkg::SRAM_BASE)
    begin
      case (6'(dw_a - trc_pkg::IO_BASE))
        trc_pkg::IO_STATUS: next_s.sreg = dw_d;
        trc_pkg::IO_STACK: next_s.stack_top_pointer = dw_d;
        trc_pkg::IO_IRQ_MASK: next_s.irq_mask = dw_d;
        trc_pkg::IO_SLEEP_CTL: next_s.slp = dw_d;
        trc_pkg::IO_EE_ADDR: next_s.eear = dw_d[6:0];
        trc_pkg::IO_EE_DATA: next_s.eedr = dw_d;
        trc_pkg::IO_EE_CTL:
        begin
          ee_we = dw_d[trc_pkg::EE_WR];
          if (dw_d[trc_pkg::EE_RD])
            next_s.eedr = eeprom[s.eear];
        end
        trc_pkg::IO_PORT_DATA: next_s.pdat = dw_d[trc_pkg::PORT_W-1:0];
        trc_pkg::IO_PORT_DIR: next_s.pdir = dw_d[trc_pkg::PORT_W-1:0];
        default: ;
      endcase
    end
    // Pin reset: pins float and the counter restarts at vector zero
    if (s.core_rst)
    begin
      next_s.st = trc_pkg::ST_HALT;
      next_s.instruction_counter = 10'h000;
      next_s.ir_ok = 1'b0;
      next_s.stack_top_pointer = trc_pkg::SP_RST;
      next_s.sreg = 8'h00;
      next_s.irq_mask = 8'h00;
      next_s.slp = 8'h00;
      next_s.pdat = '0;
      next_s.pdir = '0;
      dw_en = 1'b0;
      ee_we = 1'b0;
    end
    next_s.pull = ~next_s.pdir & next_s.pdat;
    next_s.idle = (next_s.st == trc_pkg::ST_IDLE);
    // The oscillator is modelled by clk; halt tells the clock source to stop
    next_s.osc_halt = (next_s.st == trc_pkg::ST_PDOWN);

    // ****************************************
    // Register bus
    // ****************************************
    if (axi_req.awvalid && s.rsp.awready)
    begin
      next_s.aw_ok = 1'b1;
      next_s.aw_a = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready)
    begin
      next_s.w_ok = 1'b1;
      next_s.w_d = axi_req.wdata;
      next_s.w_s = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready)
      next_s.rsp.bvalid = 1'b0;
    if (s.aw_ok && s.w_ok && !s.rsp.bvalid)
    begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = trc_pkg::RESP_OK;
      case ({s.aw_a[11:2], 2'h0})
        trc_pkg::A_CTRL: if (s.w_s[0]) next_s.run = s.w_d[trc_pkg::CTRL_RUN];
        trc_pkg::A_PADDR: if (s.w_s[1:0] == 2'h3) next_s.paddr = s.w_d[9:0];
        trc_pkg::A_DADDR: if (s.w_s[0]) next_s.daddr = s.w_d[7:0];
        trc_pkg::A_PDATA:
        begin
          pm_we = (s.w_s[1:0] == 2'h3);
          pm_d = s.w_d[15:0];
          if (pm_we)
            next_s.paddr = s.paddr + 10'h001;
        end
        trc_pkg::A_STATUS, trc_pkg::A_DDATA: ;
        default: next_s.rsp.bresp = trc_pkg::RESP_ERR;
      endcase
    end
    next_s.rsp.awready = !next_s.aw_ok && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_ok && !next_s.rsp.bvalid;
    if (s.rsp.rvalid && axi_req.rready)
      next_s.rsp.rvalid = 1'b0;
    if (axi_req.arvalid && s.rsp.arready)
    begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = trc_pkg::RESP_OK;
      case ({axi_req.araddr[11:2], 2'h0})
        trc_pkg::A_CTRL: next_s.rsp.rdata = 32'(s.run);
        trc_pkg::A_STATUS: next_s.rsp.rdata = {12'h000, s.osc_halt, s.idle,
          s.stack_top_pointer, s.instruction_counter};
        trc_pkg::A_PADDR: next_s.rsp.rdata = 32'(s.paddr);
        trc_pkg::A_PDATA: next_s.rsp.rdata = 32'(pmem[s.paddr]);
        trc_pkg::A_DADDR: next_s.rsp.rdata = 32'(s.daddr);
        trc_pkg::A_DDATA: next_s.rsp.rdata = 32'(d_rd(s.daddr));
        default:
        begin
          next_s.rsp.rdata = 32'h0000_0000;
          next_s.rsp.rresp = trc_pkg::RESP_ERR;
        end
      endcase
    end
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= trc_pkg::ST_HALT;
      s.stack_top_pointer <= trc_pkg::SP_RST;
      s.run <= trc_pkg::CTRL_RST;
      s.rst_s1 <= 1'b1;
      s.rst_s2 <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Memories hold no reset; contents survive sleep and pin reset
  always_ff @(posedge clk)
  begin
    if (dw_en && dw_a < trc_pkg::IO_BASE)
      rf[dw_a[4:0]] <= dw_d;
    if (dw_en && dw_a >= trc_pkg::SRAM_BASE && dw_a < trc_pkg::SRAM_END)
      sram[7'(dw_a - trc_pkg::SRAM_BASE)] <= dw_d;
    if (ee_we)
      eeprom[s.eear] <= s.eedr;
    if (pm_we)
      pmem[s.paddr] <= pm_d;
  end

  assign port_b_pins_out = s.pdat;
  assign port_b_pins_oe = s.pdir;
  assign port_b_pullup = s.pull;
  assign cpu_idle = s.idle;
  assign osc_halt = s.osc_halt;
  assign axi_rsp = s.rsp;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence q_run_op(logic [3:0] op);
    s.st == trc_pkg::ST_RUN && s.run && s.ir_ok && !take && s.ir[15:12] == op && !s.core_rst;
  endsequence

  a_float_in_reset: assert property (s.core_rst |=> s.pdir == '0)
    else $error("port drives during reset");
  a_reset_vector: assert property (s.core_rst |=> s.instruction_counter == 10'h000)
    else $error("counter not at vector zero");
  a_ldi_writes: assert property (q_run_op(4'hE) |=> rf[$past(dh)] == $past(k8))
    else $error("immediate load lost");
  a_seq_fetch: assert property (q_run_op(4'hE) |=>
    s.instruction_counter == $past(s.instruction_counter) + 10'h001)
    else $error("prefetch stalled");
  a_call_push: assert property (q_run_op(4'hD) |=> ##1
    s.stack_top_pointer == $past(s.stack_top_pointer, 2) - 8'h02)
    else $error("call did not push two bytes");
  a_irq_gate: assert property (!s.sreg[trc_pkg::ST_I] |-> !take)
    else $error("interrupt taken while disabled");
  a_irq_prio: assert property (take && pend[0] |=> s.instruction_counter == 10'h001)
    else $error("lower vector not served first");
  a_idle_stays: assert property (s.st == trc_pkg::ST_IDLE && pend == '0 && !s.core_rst
    |=> s.st == trc_pkg::ST_IDLE && $stable(s.instruction_counter))
    else $error("idle left without wake");
  a_pdown_halt: assert property (s.st == trc_pkg::ST_PDOWN |-> s.osc_halt)
    else $error("oscillator runs in power-down");
  a_pin_reset: assert property (!s.rst_s2 [*2] |-> ##1 s.core_rst)
    else $error("long reset pulse ignored");

endmodule : trc_core

// file: dv/trc_pins_model.sv
`timescale 1ns/1ps
// ****************************************
// Port wires with per-bit pull-up
// ****************************************
module trc_pins_model (
  input wire logic clk,
  input wire logic [trc_pkg::PORT_W-1:0] pin_out,
  input wire logic [trc_pkg::PORT_W-1:0] pin_oe,
  input wire logic [trc_pkg::PORT_W-1:0] pin_pull,
  output logic [trc_pkg::PORT_W-1:0] pin_lvl
);
  logic [trc_pkg::PORT_W-1:0] noise = 5'h0A;
  // A floating wire flips every cycle so a stale level never passes as valid
  always @(posedge clk) noise <= ~noise;
  always_comb
  begin
    for (int i = 0; i < trc_pkg::PORT_W; i++)
    begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (pin_pull[i] ? 1'b1 : noise[i]);
    end
  end
endmodule : trc_pins_model

// file: dv/tb_trc_core.sv
`timescale 1ns/1ps
module tb_trc_core;
  logic clk = 0;
  logic rst_n = 0;
  logic ext_reset_n = 1;
  logic [4:0] pins_in, pins_out, pins_oe, pins_pu;
  logic cpu_idle, osc_halt;
  trc_pkg::trc_axi_req_t req = '0;
  trc_pkg::trc_axi_rsp_t rsp;
  logic [7:0] seed = 8'h32;
  logic [7:0] k;
  logic [31:0] rdat;
  logic [1:0] r;
  logic [15:0] prog [21];
  logic [1:0] irq = 2'h0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  trc_core u_trc_core (.clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .irq_req(irq), .port_b_pins_in(pins_in), .port_b_pins_out(pins_out),
    .port_b_pins_oe(pins_oe), .port_b_pullup(pins_pu), .cpu_idle(cpu_idle),
    .osc_halt(osc_halt), .axi_req(req), .axi_rsp(rsp));
  trc_pins_model u_trc_pins_model (.clk(clk), .pin_out(pins_out), .pin_oe(pins_oe),
    .pin_pull(pins_pu), .pin_lvl(pins_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Register bus master
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rdat = rsp.rdata; r = rsp.rresp; req.rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk);
    chk({pins_oe, rsp.bvalid, rsp.rvalid}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'hFFC);
    chk(rdat, 32'h0);
    chk(32'(r), 32'(trc_pkg::RESP_ERR));
    seed = lfsr(lfsr(seed));
    k = {3'h0, seed[4:0]};
    // Vectors at 0..2, port setup, stack, mask, idle sleep, power-down sleep, handler at 19
    prog = '{16'hC002, 16'hC011, 16'h0000, 16'hE10F, 16'hBB07,
      {4'hE, k[7:4], 4'h0, k[3:0]}, 16'hBB08, 16'hED1F,
      16'hBF1D,
      16'hE013, 16'hBF1B, 16'hE210, 16'hBF15, 16'h9478, 16'h9588,
      16'hE310, 16'hBF15, 16'h9588, 16'hCFFF, 16'hEA25, 16'h9518};
    wr(trc_pkg::A_PADDR, 32'h0);
    foreach (prog[i]) wr(trc_pkg::A_PDATA, {16'h0, prog[i]});
    wr(trc_pkg::A_PADDR, 32'h5);
    rd(trc_pkg::A_PDATA);
    chk(rdat[15:0], prog[5]);
    wr(trc_pkg::A_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    chk({pins_oe, pins_out, pins_pu}, {5'h1F, k[4:0], 5'h00});
    chk({cpu_idle, osc_halt}, 32'h2);
    wr(trc_pkg::A_DADDR, 32'h10);
    rd(trc_pkg::A_DDATA);
    chk(rdat[7:0], k);
    wr(trc_pkg::A_DADDR, 32'h36);
    rd(trc_pkg::A_DDATA);
    chk(rdat[7:0], k);
    rd(trc_pkg::A_STATUS);
    chk(rdat[19:10], {2'b01, 8'hDF});
    irq <= 2'h1;
    repeat (2) @(posedge clk);
    irq <= 2'h0;
    repeat (30) @(posedge clk);
    chk({cpu_idle, osc_halt}, 32'h1);
    wr(trc_pkg::A_DADDR, 32'h12);
    rd(trc_pkg::A_DDATA);
    chk(rdat[7:0], 32'hA5);
    wr(trc_pkg::A_DADDR, 32'hDF);
    rd(trc_pkg::A_DDATA);
    chk(rdat[7:0], 32'h0F);
    // Both sources at once: the second vector would rerun setup and sleep again
    irq <= 2'h3;
    repeat (2) @(posedge clk);
    irq <= 2'h0;
    repeat (30) @(posedge clk);
    chk({cpu_idle, osc_halt}, 32'h0);
    rd(trc_pkg::A_STATUS);
    chk(rdat[17:10], 32'hDF);
    ext_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(pins_oe, 32'h0);
    ext_reset_n <= 1'b1;
    end_of_test();
  end
endmodule : tb_trc_core
